// ===== common/pabmux_pkg.sv
// constants and types for the port a/b pin function multiplexer
package pabmux_pkg;

	localparam int PABMUX_PA_PINS = 14;
	localparam int PABMUX_PB_PINS = 16;
	localparam int PABMUX_FN_NUM = 4;

	// function codes, high bit then low bit
	typedef enum logic [1:0] {
		PABMUX_FN1,
		PABMUX_FN2,
		PABMUX_FN3,
		PABMUX_FN4
	} pabmux_mode_t;

	// register byte addresses
	localparam logic [31:0] PABMUX_PA_FSEL_ADDR = 32'hfffffc80;
	localparam logic [31:0] PABMUX_PA_DIR_ADDR = 32'hfffffc82;
	localparam logic [31:0] PABMUX_PB_FSEL_LO_ADDR = 32'hfffffc88;
	localparam logic [31:0] PABMUX_PB_DIR_ADDR = 32'hfffffc8a;
	localparam logic [31:0] PABMUX_PB_FSEL_HI_ADDR = 32'hfffffc8e;

	// reset values
	localparam logic [15:0] PABMUX_PA_FSEL_RST = 16'h0000;
	localparam logic [15:0] PABMUX_PA_DIR_RST = 16'h0000;
	localparam logic [15:0] PABMUX_PB_FSEL_LO_RST = 16'h0000;
	localparam logic [15:0] PABMUX_PB_DIR_RST = 16'h0000;
	localparam logic [15:0] PABMUX_PB_FSEL_HI_RST = 16'h0000;

	// writable bits; reserved bits 15 and 14 of port a registers read zero
	localparam logic [15:0] PABMUX_PA_FSEL_MASK = 16'h3fff;
	localparam logic [15:0] PABMUX_PA_DIR_MASK = 16'h3fff;
	localparam logic [15:0] PABMUX_PB_MASK = 16'hffff;

	// functions that exist on each pin, bit k is function k+1
	localparam logic [13:0][3:0] PABMUX_PA_AVAIL = {14{4'h3}};
	localparam logic [15:0][3:0] PABMUX_PB_AVAIL = {
		4'h5, 4'h5, 4'h5, 4'hf, 4'hf, 4'h7, 4'h7, 4'h7,
		4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'hd
	};

	// which pins have a general i/o function, and its code
	localparam logic [13:0] PABMUX_PA_HAS_GPIO = 14'h3ff7;
	localparam logic [13:0][1:0] PABMUX_PA_GPIO_FN = {
		2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1,
		2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0
	};
	localparam logic [15:0] PABMUX_PB_HAS_GPIO = 16'hffff;
	localparam logic [1:0] PABMUX_PB_GPIO_FN = 2'h0;

endpackage : pabmux_pkg

// ===== core/pabmux_top.sv
// port a/b pin function multiplexer with its five control registers
// What this block does
// - each pin's function and direction set individually, no chip mode overrides it
// - software-writable registers hold function and direction for every pin
// - after reset every pin uses its first function, code zero
// - after reset every general port pin except port a pins 7 and 3 is an input
// - two-bit code selects function 1 to 4 on port b, one bit selects 1 or 2 on port a; unused codes leave pin undriven
// - codes cover port a pins 0 to 13 and port b pins 0 to 15
// - port a pins 13 to 8 offer serial channel 0 signals as function 2
// - port a pins 6,5,4,2,1,0 offer timer and network signals as function 2
// - port a pin 7 defaults to watchdog out, pin 3 to peripheral clock out
// - port b pins 15 to 11 offer async serial and bus status functions
// - port b pins 10 to 0 offer sync serial, timer, serial 2, wake functions
// - port a function register at first address; 8 and 16 bit access allowed
// - port b function select split over two registers, reset to zero
// - port a function register cleared only by power-on reset
// - port a function bits 15 and 14 read zero; software writes zero
module pabmux_top
	import pabmux_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic manual_rst_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic [15:0] bus_wdata_in,
	input wire logic [1:0] bus_be_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [15:0] bus_rdata_out,
	input wire logic [13:0][3:0] pa_fn_out_in,
	input wire logic [13:0][3:0] pa_fn_oe_in,
	output logic [13:0][3:0] pa_fn_in_out,
	input wire logic [13:0] pa_pad_in,
	output logic [13:0] pa_pad_out,
	output logic [13:0] pa_pad_oe_out,
	input wire logic [15:0][3:0] pb_fn_out_in,
	input wire logic [15:0][3:0] pb_fn_oe_in,
	output logic [15:0][3:0] pb_fn_in_out,
	input wire logic [15:0] pb_pad_in,
	output logic [15:0] pb_pad_out,
	output logic [15:0] pb_pad_oe_out
);

	logic [15:0] pa_fsel_reg;
	logic [15:0] pa_dir_reg;
	logic [15:0] pb_fsel_lo_reg;
	logic [15:0] pb_dir_reg;
	logic [15:0] pb_fsel_hi_reg;
	logic [15:0] bus_rdata_reg;
	logic [15:0] bus_rdata_next;
	logic [31:0] bus_word_addr;
	logic hit_pa_fsel;
	logic hit_pa_dir;
	logic hit_pb_fsel_lo;
	logic hit_pb_dir;
	logic hit_pb_fsel_hi;
	logic [13:0][1:0] pa_code;
	logic [15:0][1:0] pb_code;

	// byte lanes: be[1] is bits 15:8, be[0] bits 7:0
	function automatic logic [15:0] pabmux_merge(
		input logic [15:0] old_val,
		input logic [15:0] new_val,
		input logic [1:0] be,
		input logic [15:0] mask
	);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}};
		pabmux_merge = ((old_val & ~lanes) | (new_val & lanes)) & mask;
	endfunction : pabmux_merge

	// address bit 0 ignored; byte accesses use the lane enables
	assign bus_word_addr = {bus_addr_in[31:1], 1'b0};
	assign hit_pa_fsel = (bus_word_addr == PABMUX_PA_FSEL_ADDR);
	assign hit_pa_dir = (bus_word_addr == PABMUX_PA_DIR_ADDR);
	assign hit_pb_fsel_lo = (bus_word_addr == PABMUX_PB_FSEL_LO_ADDR);
	assign hit_pb_dir = (bus_word_addr == PABMUX_PB_DIR_ADDR);
	assign hit_pb_fsel_hi = (bus_word_addr == PABMUX_PB_FSEL_HI_ADDR);

	// only power-on reset clears port a function select; it survives manual reset
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			pa_fsel_reg <= PABMUX_PA_FSEL_RST;
		else if (bus_wr_in && hit_pa_fsel)
			pa_fsel_reg <= pabmux_merge(pa_fsel_reg, bus_wdata_in, bus_be_in,
				PABMUX_PA_FSEL_MASK);
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || manual_rst_in)
			pa_dir_reg <= PABMUX_PA_DIR_RST;
		else if (bus_wr_in && hit_pa_dir)
			pa_dir_reg <= pabmux_merge(pa_dir_reg, bus_wdata_in, bus_be_in,
				PABMUX_PA_DIR_MASK);
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || manual_rst_in)
			pb_fsel_lo_reg <= PABMUX_PB_FSEL_LO_RST;
		else if (bus_wr_in && hit_pb_fsel_lo)
			pb_fsel_lo_reg <= pabmux_merge(pb_fsel_lo_reg, bus_wdata_in, bus_be_in,
				PABMUX_PB_MASK);
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || manual_rst_in)
			pb_dir_reg <= PABMUX_PB_DIR_RST;
		else if (bus_wr_in && hit_pb_dir)
			pb_dir_reg <= pabmux_merge(pb_dir_reg, bus_wdata_in, bus_be_in,
				PABMUX_PB_MASK);
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || manual_rst_in)
			pb_fsel_hi_reg <= PABMUX_PB_FSEL_HI_RST;
		else if (bus_wr_in && hit_pb_fsel_hi)
			pb_fsel_hi_reg <= pabmux_merge(pb_fsel_hi_reg, bus_wdata_in, bus_be_in,
				PABMUX_PB_MASK);
	end

	// read mux; unmapped addresses answer zero, port a bits 15 and 14 stored as zero
	always_comb
	begin
		bus_rdata_next = 16'h0000;
		if (hit_pa_fsel)
			bus_rdata_next = pa_fsel_reg & PABMUX_PA_FSEL_MASK;
		else if (hit_pa_dir)
			bus_rdata_next = pa_dir_reg;
		else if (hit_pb_fsel_lo)
			bus_rdata_next = pb_fsel_lo_reg;
		else if (hit_pb_dir)
			bus_rdata_next = pb_dir_reg;
		else if (hit_pb_fsel_hi)
			bus_rdata_next = pb_fsel_hi_reg;
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			bus_rdata_reg <= 16'h0000;
		else if (bus_rd_in)
			bus_rdata_reg <= bus_rdata_next;
		else
			bus_rdata_reg <= 16'h0000;
	end

	assign bus_rdata_out = bus_rdata_reg;

	// port a carries one mode bit per pin, so its high code bit is zero
	genvar gi;
	generate
		for (gi = 0; gi < PABMUX_PA_PINS; gi++)
		begin : g_pa
			logic avail;
			logic is_gpio;
			assign pa_code[gi] = {1'b0, pa_fsel_reg[gi]};
			assign avail = PABMUX_PA_AVAIL[gi][pa_code[gi]];
			// pin 7 general i/o sits on code 1; pin 3 has none at all
			assign is_gpio = PABMUX_PA_HAS_GPIO[gi] &&
				(pa_code[gi] == PABMUX_PA_GPIO_FN[gi]);
			// no chip mode input exists, so nothing can override the selection
			always_comb
			begin
				pa_pad_out[gi] = 1'b0;
				pa_pad_oe_out[gi] = 1'b0;
				if (avail)
				begin
					pa_pad_out[gi] = pa_fn_out_in[gi][pa_code[gi]];
					if (is_gpio)
						pa_pad_oe_out[gi] = pa_dir_reg[gi];
					else
						pa_pad_oe_out[gi] = pa_fn_oe_in[gi][pa_code[gi]];
				end
			end
			// inputs reach only the selected function; others see zero
			for (genvar k = 0; k < PABMUX_FN_NUM; k++)
			begin : g_fn
				assign pa_fn_in_out[gi][k] = pa_pad_in[gi] && avail &&
					(pa_code[gi] == 2'(k));
			end
		end
	endgenerate

	generate
		for (gi = 0; gi < PABMUX_PB_PINS; gi++)
		begin : g_pb
			logic avail;
			logic is_gpio;
			if (gi < 8)
			begin : g_lo
				assign pb_code[gi] = pb_fsel_lo_reg[2*gi+1 -: 2];
			end
			else
			begin : g_hi
				assign pb_code[gi] = pb_fsel_hi_reg[2*(gi-8)+1 -: 2];
			end
			// an unused code leaves the pin undriven and inputs blocked
			assign avail = PABMUX_PB_AVAIL[gi][pb_code[gi]];
			assign is_gpio = PABMUX_PB_HAS_GPIO[gi] && (pb_code[gi] == PABMUX_PB_GPIO_FN);
			always_comb
			begin
				pb_pad_out[gi] = 1'b0;
				pb_pad_oe_out[gi] = 1'b0;
				if (avail)
				begin
					pb_pad_out[gi] = pb_fn_out_in[gi][pb_code[gi]];
					if (is_gpio)
						pb_pad_oe_out[gi] = pb_dir_reg[gi];
					else
						pb_pad_oe_out[gi] = pb_fn_oe_in[gi][pb_code[gi]];
				end
			end
			for (genvar k = 0; k < PABMUX_FN_NUM; k++)
			begin : g_fn
				assign pb_fn_in_out[gi][k] = pb_pad_in[gi] && avail &&
					(pb_code[gi] == 2'(k));
			end
		end
	endgenerate

	// checks
	// no $past here: the first edge has no history to look back on
	a_pa_fsel_por: assert property (@(posedge clk_in)
		sys_rst_in |=> (pa_fsel_reg == PABMUX_PA_FSEL_RST))
		else $error("port a function select not cleared by power-on reset");

	a_pa_fsel_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		($past(manual_rst_in) && !$past(bus_wr_in)) |-> $stable(pa_fsel_reg))
		else $error("manual reset disturbed port a function select");

	a_pb_reset_zero: assert property (@(posedge clk_in)
		(sys_rst_in || manual_rst_in) |=>
		(pb_fsel_lo_reg == PABMUX_PB_FSEL_LO_RST && pb_fsel_hi_reg == PABMUX_PB_FSEL_HI_RST &&
		pb_dir_reg == PABMUX_PB_DIR_RST && pa_dir_reg == PABMUX_PA_DIR_RST))
		else $error("port b or direction register not zero after reset");

	// pins 7 and 3 of port a are peripheral outputs in function 1
	a_reset_inputs: assert property (@(posedge clk_in)
		sys_rst_in |=> (pb_pad_oe_out == 16'h0000 &&
		(pa_pad_oe_out & 14'h3f77) == 14'h0000))
		else $error("general pins not inputs after reset");

	a_reserved_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(bus_rd_in && hit_pa_fsel) |=> (bus_rdata_out[15:14] == 2'h0))
		else $error("reserved port a bits read nonzero");

	a_write_readback: assert property (@(posedge clk_in) disable iff (sys_rst_in || manual_rst_in)
		(bus_wr_in && hit_pb_fsel_hi && bus_be_in == 2'h3) ##1
		(bus_rd_in && hit_pb_fsel_hi && !manual_rst_in) |=>
		(bus_rdata_out == $past(bus_wdata_in, 2)))
		else $error("port b high function select did not read back");

	a_read_one_cycle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!bus_rd_in |=> (bus_rdata_out == 16'h0000))
		else $error("read data held beyond its cycle");

	a_route_next: assert property (@(posedge clk_in) disable iff (sys_rst_in || manual_rst_in)
		(bus_wr_in && hit_pa_fsel && bus_be_in[0]) |=>
		(pa_code[4] == {1'b0, $past(bus_wdata_in[4])}))
		else $error("port a routing did not follow the write");

	a_gpio_dir: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[5] == 2'h0) |-> (pb_pad_oe_out[5] == pb_dir_reg[5]))
		else $error("general pin direction not from direction register");

	a_unused_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[15] == 2'h1 || pb_code[15] == 2'h3) |->
		(!pb_pad_oe_out[15] && !pb_pad_out[15] && pb_fn_in_out[15] == 4'h0))
		else $error("unused code drove a pin");

	a_pa_dir_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(bus_rd_in && hit_pa_dir) |=>
		(bus_rdata_out[15:14] == 2'h0))
		else $error("reserved port a direction bits read nonzero");

	a_pa8_serial: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pa_code[8] == 2'h1) |->
		(pa_pad_out[8] == pa_fn_out_in[8][1] && pa_pad_oe_out[8] == pa_fn_oe_in[8][1] &&
		pa_fn_in_out[8] == {2'h0, pa_pad_in[8], 1'b0}))
		else $error("port a pin 8 serial function not routed");

	a_pa4_gpio: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pa_code[4] == 2'h0) |->
		(pa_pad_oe_out[4] == pa_dir_reg[4] && pa_pad_out[4] == pa_fn_out_in[4][0]))
		else $error("port a pin 4 general function not routed");

	a_pa3_compare: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pa_code[3] == 2'h1) |->
		(pa_pad_oe_out[3] == pa_fn_oe_in[3][1] && pa_pad_out[3] == pa_fn_out_in[3][1]))
		else $error("port a pin 3 compare output not routed");

	a_pb12_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[12] == 2'h3) |->
		(pb_pad_out[12] == pb_fn_out_in[12][3] &&
		pb_pad_oe_out[12] == pb_fn_oe_in[12][3]))
		else $error("port b pin 12 bus status not routed");

	a_pb0_wake: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[0] == 2'h3) |->
		(pb_pad_out[0] == pb_fn_out_in[0][3] && pb_pad_oe_out[0] == pb_fn_oe_in[0][3]))
		else $error("port b pin 0 wake output not routed");

	a_pb3_unused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[3] == 2'h3) |->
		(!pb_pad_oe_out[3] && !pb_pad_out[3] && pb_fn_in_out[3] == 4'h0))
		else $error("port b pin 3 unused code drove the pin");

	a_pb_hi_route: assert property (@(posedge clk_in) disable iff (sys_rst_in || manual_rst_in)
		(bus_wr_in && hit_pb_fsel_hi && bus_be_in[1]) |=>
		(pb_code[15] == $past(bus_wdata_in[15:14])))
		else $error("port b routing did not follow the write");

	// a stray write must not leak into any register
	a_unmapped_write: assert property (@(posedge clk_in) disable iff (sys_rst_in || manual_rst_in)
		(bus_wr_in && !hit_pa_fsel && !hit_pa_dir && !hit_pb_fsel_lo &&
		!hit_pb_dir && !hit_pb_fsel_hi) |=>
		($stable(pa_fsel_reg) && $stable(pa_dir_reg) && $stable(pb_fsel_lo_reg) &&
		$stable(pb_dir_reg) && $stable(pb_fsel_hi_reg)))
		else $error("write to unmapped address changed a register");

	a_pb13_gpio: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pb_code[13] == 2'h0) |-> (pb_pad_oe_out[13] == pb_dir_reg[13]))
		else $error("port b pin 13 direction not from direction register");

	a_fn_in_onehot: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$onehot0(pb_fn_in_out[10]) && $onehot0(pa_fn_in_out[9]))
		else $error("pad input reached more than one function");

	a_wdt_default: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(pa_code[7] == 2'h0) |->
		(pa_pad_oe_out[7] == pa_fn_oe_in[7][0] && pa_pad_out[7] == pa_fn_out_in[7][0]))
		else $error("pin 7 first function not the peripheral source");

endmodule : pabmux_top

// ===== sim/test_pabmux_top.sv
// self-checking bench for the port a/b pin function multiplexer
module test_pabmux_top;
	timeunit 1ns;
	timeprecision 100ps;
	import pabmux_pkg::*;

	typedef struct {logic [31:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] e;} pabmux_row_t;
	logic clk_in = 0, sys_rst_in = 1, manual_rst_in = 0, bus_wr_in = 0, bus_rd_in = 0;
	logic [31:0] bus_addr_in = 0;
	logic [15:0] bus_wdata_in = 0, bus_rdata_out, pb_pad_in = 16'hffff, pb_pad_out, pb_pad_oe_out;
	logic [1:0] bus_be_in = 0;
	logic [13:0][3:0] pa_fn_out_in = {14{4'ha}}, pa_fn_oe_in = {14{4'h5}}, pa_fn_in_out;
	logic [15:0][3:0] pb_fn_out_in = {16{4'hc}}, pb_fn_oe_in = {16{4'hc}}, pb_fn_in_out;
	logic [13:0] pa_pad_in = 14'h3fff, pa_pad_out, pa_pad_oe_out;
	logic [15:0] rd_val;
	int n_fail = 0, checks_done = 0;
	// the two single-lane byte writes and the be=00 row catch a bad lane merge
	pabmux_row_t rows[8] = '{
		'{PABMUX_PA_FSEL_ADDR, 16'h3fff, 2'h3, 16'h3fff},
		'{PABMUX_PA_DIR_ADDR, 16'hffff, 2'h3, 16'h3fff},
		'{PABMUX_PB_FSEL_LO_ADDR, 16'ha5c3, 2'h3, 16'ha5c3},
		'{PABMUX_PB_DIR_ADDR, 16'h1234, 2'h3, 16'h1234},
		'{PABMUX_PB_FSEL_HI_ADDR, 16'h00ff, 2'h1, 16'h00ff},
		'{PABMUX_PB_FSEL_HI_ADDR, 16'hab00, 2'h2, 16'habff},
		'{PABMUX_PB_DIR_ADDR, 16'h5678, 2'h0, 16'h1234},
		'{32'hfffffc84, 16'hffff, 2'h3, 16'h0000}};
	logic [31:0] addrs[5] = '{PABMUX_PA_FSEL_ADDR, PABMUX_PA_DIR_ADDR, PABMUX_PB_FSEL_LO_ADDR,
		PABMUX_PB_DIR_ADDR, PABMUX_PB_FSEL_HI_ADDR};

	pabmux_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .manual_rst_in(manual_rst_in),
		.bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_be_in(bus_be_in),
		.bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out),
		.pa_fn_out_in(pa_fn_out_in), .pa_fn_oe_in(pa_fn_oe_in), .pa_fn_in_out(pa_fn_in_out),
		.pa_pad_in(pa_pad_in), .pa_pad_out(pa_pad_out), .pa_pad_oe_out(pa_pad_oe_out),
		.pb_fn_out_in(pb_fn_out_in), .pb_fn_oe_in(pb_fn_oe_in), .pb_fn_in_out(pb_fn_in_out),
		.pb_pad_in(pb_pad_in), .pb_pad_out(pb_pad_out), .pb_pad_oe_out(pb_pad_oe_out));

	initial
	begin
		forever #25 clk_in = ~clk_in;
	end

	task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	task automatic chk_pin(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] pin %s expected %h seen %h", n, e, g);
		end
	endtask : chk_pin

	task automatic bus_wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge clk_in);
		bus_wr_in <= 1'b1;
		bus_addr_in <= a;
		bus_wdata_in <= d;
		bus_be_in <= be;
		@(posedge clk_in);
		bus_wr_in <= 1'b0;
		#1;
	endtask : bus_wr

	// read data stand one cycle only, so the idle cycle after is checked too
	task automatic bus_rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge clk_in);
		bus_rd_in <= 1'b1;
		bus_addr_in <= a;
		@(posedge clk_in);
		bus_rd_in <= 1'b0;
		#1 d = bus_rdata_out;
		@(posedge clk_in);
		#1 chk_reg("rdata_idle", 16'h0000, bus_rdata_out);
	endtask : bus_rd

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#(2000 * 50);
		n_fail++;
		report_and_stop();
	end

	initial
	begin
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		#1;
		// pins 7 and 3 start on peripheral outputs, all other pins as inputs
		chk_pin("pa_oe_rst", 16'h0088, pa_pad_oe_out);
		chk_pin("pa_out_rst", 16'h0000, pa_pad_out);
		chk_pin("pb_oe_rst", 16'h0000, pb_pad_oe_out);
		chk_pin("pa_in_rst", 16'h0001, pa_fn_in_out[5]);
		foreach (addrs[i])
		begin
			bus_rd(addrs[i], rd_val);
			chk_reg("reg_rst", 16'h0000, rd_val);
		end
		$display("test reset done");
		foreach (rows[i])
		begin
			bus_wr(rows[i].a, rows[i].d, rows[i].be);
			bus_rd(rows[i].a, rd_val);
			chk_reg("reg_rw", rows[i].e, rd_val);
		end
		$display("test register table done");
		bus_wr(PABMUX_PA_FSEL_ADDR, 16'h0081, 2'h3);
		bus_wr(PABMUX_PA_DIR_ADDR, 16'h0002, 2'h3);
		chk_pin("pa_out", 16'h0081, pa_pad_out);
		chk_pin("pa_oe", 16'h000a, pa_pad_oe_out);
		chk_pin("pa0_in", 16'h0002, pa_fn_in_out[0]);
		chk_pin("pa1_in", 16'h0001, pa_fn_in_out[1]);
		// pin 15 code 01 has no function, so it must float
		bus_wr(PABMUX_PB_FSEL_HI_ADDR, 16'h6300, 2'h3);
		chk_pin("pb_out", 16'h0005, pb_pad_out[15:12]);
		chk_pin("pb_oe", 16'h0005, pb_pad_oe_out[15:12]);
		chk_pin("pb15_in", 16'h0000, pb_fn_in_out[15]);
		chk_pin("pb14_in", 16'h0004, pb_fn_in_out[14]);
		$display("test routing done");
		// write then read with no gap between the strobes
		@(posedge clk_in);
		bus_wr_in <= 1'b1;
		bus_addr_in <= PABMUX_PB_FSEL_HI_ADDR;
		bus_wdata_in <= 16'h9c3a;
		bus_be_in <= 2'h3;
		@(posedge clk_in);
		bus_wr_in <= 1'b0;
		bus_rd_in <= 1'b1;
		@(posedge clk_in);
		bus_rd_in <= 1'b0;
		#1 chk_reg("wr_rd_b2b", 16'h9c3a, bus_rdata_out);
		$display("test back to back done");
		@(posedge clk_in);
		manual_rst_in <= 1'b1;
		@(posedge clk_in);
		manual_rst_in <= 1'b0;
		bus_rd(PABMUX_PA_FSEL_ADDR, rd_val);
		chk_reg("pa_fsel_kept", 16'h0081, rd_val);
		bus_rd(PABMUX_PB_FSEL_HI_ADDR, rd_val);
		chk_reg("pb_hi_clr", 16'h0000, rd_val);
		bus_rd(PABMUX_PA_DIR_ADDR, rd_val);
		chk_reg("pa_dir_clr", 16'h0000, rd_val);
		$display("test manual reset done");
		report_and_stop();
	end

endmodule : test_pabmux_top
